/* File: hw/tbir_top.sv */
`timescale 1ns/100ps
module tbir_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register bus
   input tbir_pkg::tbir_wb_req_s wb_req_i,
   output tbir_pkg::tbir_wb_rsp_s wb_rsp_o,
   // Trace input port, from the upstream source
   input tbir_pkg::tbir_atb_in_s atb_i,
   output tbir_pkg::tbir_atb_out_s atb_o,
   // Functional capture logic
   input tbir_pkg::tbir_atb_out_s func_atb_i,
   output logic capture_en_o,
   // Status
   output logic integration_mode_select_o,
   output logic [3:0] ownership_tag_o
);
   import tbir_pkg::*;

   tbir_bank_state_s st_reg;
   tbir_bank_state_s st_next;
   logic wr_stb;
   logic [31:0] rd_mux;
   logic [TBIR_PROBE_BITS-1:0] data_probe;
   logic [31:0] data_probe_word;
   logic [31:0] id_probe_word;
   logic [31:0] ctrl_probe_word;
   logic [31:0] mode_word;
   logic [31:0] tag_set_word;
   logic [31:0] tag_view_word;
   logic lane0;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave
   tbir_wb_slave u_slave (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_req_i(wb_req_i),
      .wb_rsp_o(wb_rsp_o),
      .rd_data_i(rd_mux),
      .wr_stb_o(wr_stb)
   );

   ////////////////////////////////////////////////////////////////////////
   // Live input probes
   // data bit picks
   generate
      for (genvar i = 0; i < TBIR_PROBE_BITS; i++) begin : g_probe
         assign data_probe[i] = atb_i.data[TBIR_PROBE_SRC[i]];
      end
   endgenerate

   // Probe words; reserved bits stay zero
   always_comb begin
      data_probe_word = 32'h0000_0000;
      id_probe_word = 32'h0000_0000;
      ctrl_probe_word = 32'h0000_0000;
      mode_word = 32'h0000_0000;
      tag_set_word = 32'h0000_0000;
      tag_view_word = 32'h0000_0000;
      data_probe_word[TBIR_PROBE_BITS-1:0] = data_probe;
      id_probe_word[TBIR_ID_W-1:0] = atb_i.id;
      ctrl_probe_word[TBIR_BYTES_LSB +: TBIR_BYTES_W] = atb_i.bytes;
      ctrl_probe_word[TBIR_AFREADY_POS] = atb_i.afready;
      ctrl_probe_word[TBIR_VALID_POS] = atb_i.valid;
      mode_word[TBIR_MODE_POS] = st_reg.mode;
      tag_set_word[TBIR_TAG_W-1:0] = TBIR_TAG_IMPL;
      tag_view_word[TBIR_TAG_W-1:0] = st_reg.tag;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read decode; drive register is write only and reads zero
   always_comb begin
      case (wb_req_i.adr)
         TBIR_OFS_DATA_PROBE: begin
            rd_mux = data_probe_word;
         end
         TBIR_OFS_ID_PROBE: begin
            rd_mux = id_probe_word;
         end
         TBIR_OFS_CTRL_PROBE: begin
            rd_mux = ctrl_probe_word;
         end
         TBIR_OFS_MODE: begin
            rd_mux = mode_word;
         end
         TBIR_OFS_TAG_SET: begin
            rd_mux = tag_set_word;
         end
         TBIR_OFS_TAG_VIEW: begin
            rd_mux = tag_view_word;
         end
         default: begin
            // Unmapped addresses still ack, with zero data
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes
   // Every writable field lives in byte lane 0
   assign lane0 = wr_stb & wb_req_i.sel[0];

   always_comb begin
      st_next = st_reg;
      if (lane0) begin
         case (wb_req_i.adr)
            TBIR_OFS_READY_FLUSH: begin
               st_next.drv_atready = wb_req_i.dat[TBIR_READY_POS];
               st_next.drv_afvalid = wb_req_i.dat[TBIR_AFVALID_POS];
            end
            TBIR_OFS_MODE: begin
               st_next.mode = wb_req_i.dat[TBIR_MODE_POS];
            end
            TBIR_OFS_TAG_SET: begin
               st_next.tag = st_reg.tag | wb_req_i.dat[TBIR_TAG_W-1:0];
            end
            default: begin
               // Read-only and unmapped offsets drop the write
               st_next = st_reg;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= TBIR_BANK_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output steering
   // integration override
   assign atb_o.atready = st_reg.mode ? st_reg.drv_atready : func_atb_i.atready;
   assign atb_o.afvalid = st_reg.mode ? st_reg.drv_afvalid : func_atb_i.afvalid;

   assign capture_en_o = ~st_reg.mode;

   assign integration_mode_select_o = st_reg.mode;

   assign ownership_tag_o = st_reg.tag;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_read(logic [11:0] ofs);
      wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr == ofs;
   endsequence

   sequence s_write(logic [11:0] ofs);
      wb_rsp_o.ack && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_req_i.sel[0]
         && wb_req_i.adr == ofs;
   endsequence

   chk_data_probe_map: assert property (s_read(TBIR_OFS_DATA_PROBE) |->
      wb_rsp_o.dat == {27'h0, $past(atb_i.data[31]), $past(atb_i.data[23]),
      $past(atb_i.data[15]), $past(atb_i.data[7]), $past(atb_i.data[0])})
      else $error("data probe bits wrong");

   chk_drive_write_lands: assert property (s_write(TBIR_OFS_READY_FLUSH) ##0
      st_reg.mode ##1 st_reg.mode |-> atb_o.atready == $past(wb_req_i.dat[0])
      && atb_o.afvalid == $past(wb_req_i.dat[1]))
      else $error("drive register write not on outputs");

   chk_id_probe_value: assert property (s_read(TBIR_OFS_ID_PROBE) |->
      wb_rsp_o.dat == {25'h0, $past(atb_i.id)})
      else $error("id probe wrong");

   chk_ctrl_probe_value: assert property (s_read(TBIR_OFS_CTRL_PROBE) |->
      wb_rsp_o.dat == {22'h0, $past(atb_i.bytes), 6'h0, $past(atb_i.afready),
      $past(atb_i.valid)})
      else $error("control probe wrong");

   chk_mode_write_takes: assert property (s_write(TBIR_OFS_MODE) |=>
      integration_mode_select_o == $past(wb_req_i.dat[0]))
      else $error("mode bit did not take write");

   chk_capture_suspend: assert property (s_write(TBIR_OFS_MODE) ##0 wb_req_i.dat[0]
      |=> !capture_en_o)
      else $error("capture not suspended in integration mode");

   chk_tag_set_only: assert property (s_write(TBIR_OFS_TAG_SET) |=>
      ownership_tag_o == ($past(ownership_tag_o) | $past(wb_req_i.dat[3:0])))
      else $error("tag set wrong");

   chk_tag_impl_read: assert property (s_read(TBIR_OFS_TAG_SET) |->
      wb_rsp_o.dat == 32'h0000_000f)
      else $error("tag set read wrong");

   chk_mode_reserved_zero: assert property (s_read(TBIR_OFS_MODE) |->
      wb_rsp_o.dat[31:1] == 31'h0)
      else $error("reserved bits not zero");

   chk_func_path_pass: assert property (!integration_mode_select_o |->
      atb_o.atready == func_atb_i.atready && atb_o.afvalid == func_atb_i.afvalid)
      else $error("functional outputs not passed through");

   // tags stay put without a set write
   chk_tag_stable: assert property (!wr_stb |=> $stable(ownership_tag_o))
      else $error("tag changed without write");

   chk_mode_hold: assert property (!wr_stb |=> $stable(integration_mode_select_o))
      else $error("mode changed without write");

   // register writes only land on an ack
   chk_wr_needs_ack: assert property (wr_stb |-> wb_rsp_o.ack)
      else $error("write strobe without ack");

   chk_capture_mirror: assert property (capture_en_o == !integration_mode_select_o)
      else $error("capture enable does not mirror mode");

   chk_drive_holds: assert property ((integration_mode_select_o && !wr_stb) ##1
      integration_mode_select_o |-> $stable(atb_o))
      else $error("drive outputs moved without a write");

   chk_data_probe_reserved: assert property (s_read(TBIR_OFS_DATA_PROBE) |->
      wb_rsp_o.dat[31:5] == 27'h0)
      else $error("data probe reserved bits not zero");

   chk_drive_reads_zero: assert property (s_read(TBIR_OFS_READY_FLUSH) |->
      wb_rsp_o.dat == 32'h0000_0000)
      else $error("drive register read not zero");

   chk_unmapped_zero: assert property ((wb_rsp_o.ack && !wb_req_i.we
      && wb_req_i.adr > TBIR_OFS_TAG_VIEW) |-> wb_rsp_o.dat == 32'h0000_0000)
      else $error("unmapped read not zero");

   // writes with lane zero off are dropped
   chk_lane_off_ignored: assert property ((wb_rsp_o.ack && wb_req_i.cyc
      && wb_req_i.stb && wb_req_i.we && !wb_req_i.sel[0])
      |=> $stable(integration_mode_select_o) && $stable(ownership_tag_o))
      else $error("write with lane zero off took effect");

   chk_tag_view_read: assert property (s_read(TBIR_OFS_TAG_VIEW) |->
      wb_rsp_o.dat == {28'h0, $past(ownership_tag_o)})
      else $error("tag view read wrong");

   chk_tag_no_clear: assert property (1'b1 |=>
      (ownership_tag_o & $past(ownership_tag_o)) == $past(ownership_tag_o))
      else $error("tag bit cleared by a write");

   // Response data stays quiet between acks
   chk_rsp_quiet: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0000_0000)
      else $error("read data outside ack");

   cov_enter_integration: cover property (s_write(TBIR_OFS_MODE) ##0 wb_req_i.dat[0]);
   cov_probe_valid_read: cover property (s_read(TBIR_OFS_DATA_PROBE) ##0 $past(atb_i.valid));
   cov_tag_set: cover property (s_write(TBIR_OFS_TAG_SET) ##1 ownership_tag_o != 4'h0);
   cov_drive_flush: cover property (st_reg.mode && atb_o.afvalid);
   cov_back_to_func: cover property (s_write(TBIR_OFS_MODE) ##0 !wb_req_i.dat[0] ##1 capture_en_o);

endmodule // tbir_top

/* File: hw/tbir_pkg.sv */
package tbir_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses on the bus
   localparam int unsigned TBIR_ADR_W = 12;
   localparam logic [11:0] TBIR_OFS_DATA_PROBE = 12'h000;
   localparam logic [11:0] TBIR_OFS_READY_FLUSH = 12'h004;
   localparam logic [11:0] TBIR_OFS_ID_PROBE = 12'h008;
   localparam logic [11:0] TBIR_OFS_CTRL_PROBE = 12'h00c;
   localparam logic [11:0] TBIR_OFS_MODE = 12'h010;
   localparam logic [11:0] TBIR_OFS_TAG_SET = 12'h014;
   localparam logic [11:0] TBIR_OFS_TAG_VIEW = 12'h018;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int unsigned TBIR_PROBE_BITS = 5;
   // Incoming data bit sampled into probe bit i
   localparam int TBIR_PROBE_SRC [TBIR_PROBE_BITS] = '{0, 7, 15, 23, 31};
   localparam int unsigned TBIR_READY_POS = 0;
   localparam int unsigned TBIR_AFVALID_POS = 1;
   localparam int unsigned TBIR_ID_W = 7;
   localparam int unsigned TBIR_BYTES_LSB = 8;
   localparam int unsigned TBIR_BYTES_W = 2;
   localparam int unsigned TBIR_VALID_POS = 0;
   localparam int unsigned TBIR_AFREADY_POS = 1;
   localparam int unsigned TBIR_MODE_POS = 0;
   localparam int unsigned TBIR_TAG_W = 4;

   ////////////////////////////////////////////////////////////////////////
   // Reset and fixed values
   localparam logic TBIR_MODE_RST = 1'b0;
   localparam logic TBIR_DRIVE_RST = 1'b0;
   localparam logic [3:0] TBIR_TAG_RST = 4'h0;
   localparam logic [3:0] TBIR_TAG_IMPL = 4'hf;

   ////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic [31:0] data;
      logic [6:0] id;
      logic [1:0] bytes;
      logic valid;
      logic afready;
   } tbir_atb_in_s;

   typedef struct packed {
      logic atready;
      logic afvalid;
   } tbir_atb_out_s;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [11:0] adr;
      logic [31:0] dat;
   } tbir_wb_req_s;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } tbir_wb_rsp_s;

   // State of the bus slave
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
   } tbir_slv_state_s;

   // State of the register bank
   typedef struct packed {
      logic mode;
      logic drv_atready;
      logic drv_afvalid;
      logic [3:0] tag;
   } tbir_bank_state_s;

   localparam tbir_slv_state_s TBIR_SLV_RST = '{ack: 1'b0, rdat: 32'h0000_0000};
   localparam tbir_bank_state_s TBIR_BANK_RST = '{
      mode: TBIR_MODE_RST,
      drv_atready: TBIR_DRIVE_RST,
      drv_afvalid: TBIR_DRIVE_RST,
      tag: TBIR_TAG_RST
   };

endpackage

/* File: hw/tbir_wb_slave.sv */
`timescale 1ns/100ps
module tbir_wb_slave (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus side
   input tbir_pkg::tbir_wb_req_s wb_req_i,
   output tbir_pkg::tbir_wb_rsp_s wb_rsp_o,
   // Register bank side
   input wire logic [31:0] rd_data_i,
   output logic wr_stb_o
);
   import tbir_pkg::*;

   tbir_slv_state_s st_reg;
   tbir_slv_state_s st_next;
   logic start;

   ////////////////////////////////////////////////////////////////////////
   // Ack one cycle after the request; read data caught with it
   assign start = wb_req_i.cyc & wb_req_i.stb & ~st_reg.ack;

   always_comb begin
      st_next = st_reg;
      st_next.ack = start;
      // Capturing at request time keeps data stable for the whole ack cycle
      st_next.rdat = (start & ~wb_req_i.we) ? rd_data_i : 32'h0000_0000;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= TBIR_SLV_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // Write lands on the edge where the master sees ack
   assign wr_stb_o = st_reg.ack & wb_req_i.cyc & wb_req_i.stb & wb_req_i.we;
   assign wb_rsp_o.ack = st_reg.ack;
   assign wb_rsp_o.dat = st_reg.rdat;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_ack_single_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
      else $error("ack held for more than one cycle");
   chk_ack_one_cycle: assert property (
      (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack) |=> wb_rsp_o.ack)
      else $error("request not acknowledged in one cycle");

endmodule // tbir_wb_slave

/* File: verif/tbir_src_model.sv */
`timescale 1ns/100ps
// Upstream trace source: offers one beat until the sink takes it
module tbir_src_model
   import tbir_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Beat to offer
   input wire logic load_i,
   input tbir_atb_in_s beat_i,
   // Sink side
   input tbir_atb_out_s sink_i,
   output tbir_atb_in_s atb_o
);
   tbir_atb_in_s beat_reg;
   ////////////////////////////////////////////////////////////////
   // payload only meaningful with valid
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         beat_reg <= '0;
      end else if (load_i) begin
         beat_reg <= beat_i;
      end else if (beat_reg.valid && sink_i.atready) begin
         // Taken: released lines flip so stale values never pass
         beat_reg.data <= ~beat_reg.data;
         beat_reg.id <= ~beat_reg.id;
         beat_reg.bytes <= ~beat_reg.bytes;
         beat_reg.valid <= 1'b0;
      end
   end
   assign atb_o = beat_reg;
endmodule // tbir_src_model

/* File: verif/tb_tbir_top.sv */
`timescale 1ns/100ps
module tb_tbir_top;
   import tbir_pkg::*;
   // Bench signals
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   tbir_wb_req_s wb_req = '0;
   tbir_wb_rsp_s wb_rsp;
   tbir_atb_in_s src_atb;
   tbir_atb_in_s beat = '0;
   tbir_atb_out_s atb_out;
   tbir_atb_out_s func_atb = '0;
   logic load = 1'b0;
   logic capture_en;
   logic mode_sel;
   logic [3:0] tag_bits;
   logic [31:0] q;
   int miscompares = 0;
   int cmp_count = 0;

   always #5 clk_i = ~clk_i;

   tbir_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
      .atb_i(src_atb), .atb_o(atb_out), .func_atb_i(func_atb), .capture_en_o(capture_en),
      .integration_mode_select_o(mode_sel), .ownership_tag_o(tag_bits));
   tbir_src_model src_u (.clk_i(clk_i), .rst_i(rst_i), .load_i(load), .beat_i(beat),
      .sink_i(atb_out), .atb_o(src_atb));

   ////////////////////////////////////////////////////////////////
   // Verdict, the only exit
   task automatic complete_run();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One classic cycle; ack and data are taken at the rising edge that samples ack
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [31:0] r);
      int n;
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: s, adr: a, dat: d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_rsp.ack !== 1'b1 && n < 20);
      if (wb_rsp.ack !== 1'b1) begin
         miscompares++;
         complete_run();
      end
      r = wb_rsp.dat;
      wb_req <= '0;
      // One idle cycle between requests
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, 4'hf, r);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      wb(1'b0, a, 32'h0, 4'hf, r);
      chk(r, exp);
   endtask

   ////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset_vals();
      rd(TBIR_OFS_MODE, 32'h0);
      rd(TBIR_OFS_TAG_VIEW, 32'h0);
      rd(TBIR_OFS_TAG_SET, 32'hf);
      rd(TBIR_OFS_READY_FLUSH, 32'h0);
      func_atb <= '{atready: 1'b1, afvalid: 1'b0};
      @(negedge clk_i);
      chk({30'h0, atb_out}, 32'h2);
      chk({31'h0, capture_en}, 32'h1);
      @(posedge clk_i);
      func_atb <= '0;
   endtask

   task automatic t_probes();
      tbir_atb_in_s b [3];
      b[0] = '{data: 32'h8000_0001, id: 7'h7f, bytes: 2'h3, valid: 1'b1, afready: 1'b1};
      b[1] = '{data: 32'h0080_8080, id: 7'h2a, bytes: 2'h1, valid: 1'b1, afready: 1'b0};
      b[2] = '{data: 32'h7f7f_7f7e, id: 7'h55, bytes: 2'h2, valid: 1'b1, afready: 1'b1};
      foreach (b[i]) begin
         load <= 1'b1;
         beat <= b[i];
         @(posedge clk_i);
         load <= 1'b0;
         @(posedge clk_i);
         rd(TBIR_OFS_DATA_PROBE, {27'h0, b[i].data[31], b[i].data[23], b[i].data[15],
            b[i].data[7], b[i].data[0]});
         rd(TBIR_OFS_ID_PROBE, {25'h0, b[i].id});
         rd(TBIR_OFS_CTRL_PROBE, {22'h0, b[i].bytes, 6'h0, b[i].afready, 1'b1});
      end
   endtask

   task automatic t_drive();
      logic [1:0] v;
      wr(TBIR_OFS_MODE, 32'hffff_ffff);
      rd(TBIR_OFS_MODE, 32'h1);
      chk({30'h0, mode_sel, capture_en}, 32'h2);
      for (int i = 0; i < 4; i++) begin
         v = i[1:0];
         func_atb <= '{atready: ~v[0], afvalid: ~v[1]};
         wr(TBIR_OFS_READY_FLUSH, {30'h3fff_ffff, v});
         @(negedge clk_i);
         chk({30'h0, atb_out}, {30'h0, v[0], v[1]});
         @(posedge clk_i);
      end
      // Source saw ready, so its beat is gone and byte lines flipped
      rd(TBIR_OFS_CTRL_PROBE, 32'h102);
      rd(TBIR_OFS_READY_FLUSH, 32'h0);
      func_atb <= '0;
      wr(TBIR_OFS_MODE, 32'h0);
      @(negedge clk_i);
      chk({30'h0, atb_out}, 32'h0);
      chk({31'h0, capture_en}, 32'h1);
      @(posedge clk_i);
   endtask

   task automatic t_tags();
      wr(TBIR_OFS_TAG_SET, 32'hffff_fff5);
      rd(TBIR_OFS_TAG_VIEW, 32'h5);
      wr(TBIR_OFS_TAG_SET, 32'h0);
      wb(1'b1, TBIR_OFS_TAG_SET, 32'h8, 4'he, q);
      wr(TBIR_OFS_TAG_SET, 32'h2);
      rd(TBIR_OFS_TAG_VIEW, 32'h7);
      chk({28'h0, tag_bits}, 32'h7);
      rd(TBIR_OFS_TAG_SET, 32'hf);
      rd(TBIR_OFS_MODE, 32'h0);
      rd(12'h100, 32'h0);
   endtask

   task automatic t_rereset();
      wr(TBIR_OFS_MODE, 32'h1);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(TBIR_OFS_MODE, 32'h0);
      rd(TBIR_OFS_TAG_VIEW, 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset_vals();
      t_probes();
      t_drive();
      t_tags();
      t_rereset();
      complete_run();
   end
endmodule // tb_tbir_top
